/* File: shared/flash_seq_pkg.sv */
/*
  Constants shared by the flash command sequencer: opcodes, phase lengths
  in serial clocks, field positions, reset values and state encodings.
  Assumes a 25 MHz block clock.
*/
`default_nettype none
package flash_seq_pkg;
  // block clock and program cycle
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 700000;

  // opcodes
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_STAT_LO = 8'h05;
  localparam logic [7:0] OP_STAT_HI = 8'h35;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD = 8'he7;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;

  // phase lengths in serial clocks
  localparam logic [5:0] OPC_CLKS = 6'h08;
  localparam logic [5:0] BYTE_CLKS = 6'h08;
  localparam logic [5:0] SER_ADDR_CLKS = 6'h18;
  localparam logic [5:0] DUAL_ADDR_CLKS = 6'h0c;
  localparam logic [5:0] QUAD_ADDR_CLKS = 6'h06;
  localparam logic [5:0] DUAL_MODE_CLKS = 6'h04;
  localparam logic [5:0] QUAD_MODE_CLKS = 6'h02;
  localparam logic [5:0] QIO_DUMMY_CLKS = 6'h04;
  localparam logic [5:0] QWORD_DUMMY_CLKS = 6'h02;
  localparam logic [5:0] WRAP_FRAME_CLKS = 6'h08;

  // lane codes
  localparam logic [1:0] LANE1 = 2'h0;
  localparam logic [1:0] LANE2 = 2'h1;
  localparam logic [1:0] LANE4 = 2'h2;

  // field positions and values
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam logic [1:0] CONT_MATCH = 2'h2;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_HI = 6;
  localparam int WRAP_LEN_LO = 5;
  localparam logic [7:0] WRAP_MIN_LEN = 8'h08;
  localparam int STAT_WIP_POS = 0;
  localparam int STAT_WEL_POS = 1;
  localparam int STAT_QE_POS = 1;

  // reset values
  localparam logic WRAP_DIS_RST = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST = 2'h0;
  localparam logic [5:0] LINK_RST = 6'h20;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_OPC = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_MODE = 4'b0011,
    ST_DUMMY = 4'b0100,
    ST_DOUT = 4'b0101,
    ST_WRAP = 4'b0110,
    ST_PDATA = 4'b0111,
    ST_SOUT = 4'b1000,
    ST_DONE = 4'b1001,
    ST_SKIP = 4'b1010
  } frame_st_t;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_COPY = 2'b01,
    P_WAIT = 2'b10
  } prog_st_t;
endpackage
`default_nettype wire

/* File: design/sync2.sv */
/*
  Two-flop synchroniser for a bundle of levels.
  Assumes each bit is a slow level relative to the clock.
*/
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

/* File: design/page_buf.sv */
/*
  Page latch: one byte and one written flag per column, registered read.
  Assumes clear and write never land in the same cycle.
*/
`default_nettype none
module page_buf #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // drain side
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff
);
  logic [7:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_ff;

  // a later byte to the same column simply overwrites the earlier one
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= '0;
    end else if (clr) begin
      valid_ff <= '0;
    end else if (wr_en) begin
      valid_ff[wr_addr] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff <= mem[rd_addr];
      rd_valid_ff <= valid_ff[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: design/flash_cmd_seq.sv */
/*
  Serial flash command sequencer: dual and quad I/O reads with continuous
  read mode and wrap bursts, wrap setup, page program, status reads.
  Assumes the array answers a read address one clock later, and that the
  link pins are asynchronous and slow against the 25 MHz block clock.
*/
// Summary of operation
// - dual read: address, mode two bits per clock
// - read address increments per byte until deselect
// - mode bits 10 skip next dual opcode
// - other mode bits need full opcode next
// - quad read: address, mode, four dummies, quad
// - quad reads need quad enable bit set
// - mode bits 10 skip next quad opcode
// - word quad read has two dummy clocks
// - mode bits 10 skip next word opcode
// - wrap burst stays within aligned section
// - wrap setting holds for later quad reads
// - wrap disable bit one turns wrap off
// - wrap length bits choose 8 to 64
// - page program needs write enable latch
// - program data wraps within its page
// - last 256 bytes kept, others untouched
// - program only on whole byte deselect
// - deselect starts timed cycle, busy flag set
// - protected pages are never programmed
// - write enable sets latch, program clears it
// - quad enable is status bit nine
`default_nettype none
module flash_cmd_seq
  import flash_seq_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // serial link
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic [3:0] QUAD_LINE_IN,
  output logic [3:0] QUAD_LINE_OUT,
  output logic [3:0] QUAD_LINE_OE,
  // status bits shared with the device
  input wire logic QUAD_ENABLE_BIT,
  input wire logic [4:0] BLOCK_PROTECT_BITS,
  output logic WRITE_ENABLE_LATCH,
  output logic WRITE_IN_PROGRESS,
  output logic WRAP_DISABLE_BIT,
  output logic [1:0] WRAP_LENGTH_BITS,
  output logic CONTINUOUS_MODE_ACTIVE,
  // array read port
  output logic [23:0] ARRAY_RD_ADDR,
  input wire logic [7:0] ARRAY_RD_DATA,
  // array program port
  output logic ARRAY_WR_EN,
  output logic [23:0] ARRAY_WR_ADDR,
  output logic [7:0] ARRAY_WR_DATA
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                           input logic [1:0] lane);
    case (lane)
      LANE2: shift_in = {sh[21:0], io[1:0]};
      LANE4: shift_in = {sh[19:0], io};
      default: shift_in = {sh[22:0], io[0]};
    endcase
  endfunction

  // single lane answers on line 1, as a plain serial output would
  function automatic logic [3:0] emit(input logic [7:0] b, input logic [1:0] lane);
    case (lane)
      LANE2: emit = {2'h0, b[7:6]};
      LANE4: emit = b[7:4];
      default: emit = {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input logic [1:0] lane);
    case (lane)
      LANE2: lane_mask = 4'h3;
      LANE4: lane_mask = 4'hf;
      default: lane_mask = 4'h2;
    endcase
  endfunction

  // bp[2:0] sets how many 64 KB blocks are locked, bp[3] picks the bottom
  function automatic logic is_protected(input logic [4:0] bp, input logic [7:0] blk);
    logic [8:0] n;
    n = 9'h001 << (bp[2:0] - 3'h1);
    if (bp[2:0] == 3'h0) begin
      is_protected = 1'b0;
    end else if (bp[2:0] == 3'h7) begin
      is_protected = 1'b1;
    end else if (bp[3]) begin
      is_protected = ({1'b0, blk} < n);
    end else begin
      is_protected = ({1'b0, blk} >= (9'h100 - n));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic rst_meta_ff, rst_n_ff;
  logic [5:0] link_s;
  logic cs_s, sclk_s, sclk_d_ff, cs_d_ff;
  logic [3:0] io_s;
  logic sclk_rise, sclk_fall, cs_rise;
  frame_st_t st_ff;
  prog_st_t pst_ff;
  logic [5:0] cnt_ff;
  logic [23:0] sh_ff, nxt_sh, addr_ff, nxt_addr;
  logic [7:0] cmd_ff, cont_cmd_ff, op, col_ff, wmask, stat_byte;
  logic [1:0] lane_ff, wrap_len_ff;
  logic cont_ff, wrap_dis_ff, got_byte_ff, wel_ff, wip_ff, wrap_on;
  logic op_last, byte_start, start_pgm, pb_we, pb_clr, pb_valid, wel_drop;
  logic [7:0] pb_data;
  logic [8:0] pcol_ff;
  logic [23:0] ptimer_ff;
  logic [15:0] page_ff;
  logic [3:0] out_ff, oe_ff;
  logic [7:0] obyte_ff;
  logic [2:0] slot_ff;
  logic wr_en_ff;
  logic [23:0] wr_addr_ff;
  logic [7:0] wr_data_ff;

  // reset released through two flops so no flop leaves reset mid-edge
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  sync2 #(.W(6), .RST_VAL(LINK_RST)) u_link_sync (
    .clk(REF_CLK),
    .rst_n(rst_n_ff),
    .d({CS_N, SCLK, QUAD_LINE_IN}),
    .q(link_s)
  );

  assign cs_s = link_s[5];
  assign sclk_s = link_s[4];
  assign io_s = link_s[3:0];

  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;
  assign cs_rise = cs_s & ~cs_d_ff;

  ////////////////////////////////////////////////////////////////////////
  assign nxt_sh = shift_in(sh_ff, io_s, lane_ff);
  assign op = nxt_sh[7:0];
  assign op_last = sclk_rise && !cs_s && st_ff == ST_OPC && cnt_ff == 6'h01;
  assign wrap_on = !wrap_dis_ff && (cmd_ff == OP_QUAD_IO || cmd_ff == OP_QUAD_WORD);
  assign wmask = (WRAP_MIN_LEN << wrap_len_ff) - 8'h01;
  assign nxt_addr = wrap_on ? {addr_ff[23:8], (addr_ff[7:0] & ~wmask) | ((addr_ff[7:0] + 8'h01) & wmask)}
                            : addr_ff + 24'h000001;
  assign pb_we = sclk_rise && !cs_s && st_ff == ST_PDATA && cnt_ff == 6'h01;
  assign pb_clr = op_last && op == OP_PAGE_PROG && wel_ff && !wip_ff;

  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 6'h00;
      sh_ff <= 24'h000000;
      cmd_ff <= 8'h00;
      lane_ff <= LANE1;
      addr_ff <= 24'h000000;
      col_ff <= 8'h00;
      got_byte_ff <= 1'b0;
      cont_ff <= 1'b0;
      cont_cmd_ff <= 8'h00;
      wrap_dis_ff <= WRAP_DIS_RST;
      wrap_len_ff <= WRAP_LEN_RST;
    end else if (cs_s) begin
      st_ff <= ST_IDLE;
    end else if (st_ff == ST_IDLE) begin
      got_byte_ff <= 1'b0;
      if (cont_ff) begin
        // frame opens straight on the address
        st_ff <= ST_ADDR;
        cmd_ff <= cont_cmd_ff;
        lane_ff <= (cont_cmd_ff == OP_DUAL_IO) ? LANE2 : LANE4;
        cnt_ff <= (cont_cmd_ff == OP_DUAL_IO) ? DUAL_ADDR_CLKS : QUAD_ADDR_CLKS;
      end else begin
        st_ff <= ST_OPC;
        lane_ff <= LANE1;
        cnt_ff <= OPC_CLKS;
      end
    end else if (sclk_rise) begin
      sh_ff <= nxt_sh;
      cnt_ff <= cnt_ff - 6'h01;
      if (st_ff == ST_DONE) begin
        st_ff <= ST_SKIP;
      end else if (cnt_ff == 6'h01) begin
        unique case (st_ff)
          ST_OPC: begin
            cmd_ff <= op;
            st_ff <= ST_SKIP;
            if (wip_ff && op != OP_STAT_LO && op != OP_STAT_HI) begin
              st_ff <= ST_SKIP;
            end else if (op == OP_DUAL_IO) begin
              st_ff <= ST_ADDR;
              lane_ff <= LANE2;
              cnt_ff <= DUAL_ADDR_CLKS;
            end else if (op == OP_QUAD_IO || op == OP_QUAD_WORD) begin
              if (QUAD_ENABLE_BIT) begin
                st_ff <= ST_ADDR;
                lane_ff <= LANE4;
                cnt_ff <= QUAD_ADDR_CLKS;
              end
            end else if (op == OP_SET_WRAP) begin
              st_ff <= ST_WRAP;
              lane_ff <= LANE4;
              cnt_ff <= WRAP_FRAME_CLKS;
            end else if (op == OP_PAGE_PROG) begin
              if (wel_ff) begin
                st_ff <= ST_ADDR;
                cnt_ff <= SER_ADDR_CLKS;
              end
            end else if (op == OP_STAT_LO || op == OP_STAT_HI) begin
              st_ff <= ST_SOUT;
            end else if (op == OP_WR_ENABLE || op == OP_WR_DISABLE) begin
              st_ff <= ST_DONE;
            end
          end
          ST_ADDR: begin
            addr_ff <= nxt_sh;
            col_ff <= nxt_sh[7:0];
            if (cmd_ff == OP_PAGE_PROG) begin
              st_ff <= is_protected(BLOCK_PROTECT_BITS, nxt_sh[23:16]) ? ST_SKIP : ST_PDATA;
              cnt_ff <= BYTE_CLKS;
            end else begin
              st_ff <= ST_MODE;
              cnt_ff <= (cmd_ff == OP_DUAL_IO) ? DUAL_MODE_CLKS : QUAD_MODE_CLKS;
            end
          end
          ST_MODE: begin
            cont_ff <= (nxt_sh[MODE_HI:MODE_LO] == CONT_MATCH);
            cont_cmd_ff <= cmd_ff;
            if (cmd_ff == OP_DUAL_IO) begin
              st_ff <= ST_DOUT;
            end else begin
              st_ff <= ST_DUMMY;
              cnt_ff <= (cmd_ff == OP_QUAD_IO) ? QIO_DUMMY_CLKS : QWORD_DUMMY_CLKS;
            end
          end
          ST_DUMMY: begin
            st_ff <= ST_DOUT;
          end
          ST_WRAP: begin
            wrap_dis_ff <= nxt_sh[WRAP_DIS_POS];
            wrap_len_ff <= nxt_sh[WRAP_LEN_HI:WRAP_LEN_LO];
            st_ff <= ST_DONE;
          end
          ST_PDATA: begin
            col_ff <= col_ff + 8'h01;
            got_byte_ff <= 1'b1;
            cnt_ff <= BYTE_CLKS;
          end
          ST_IDLE, ST_DOUT, ST_SOUT, ST_DONE, ST_SKIP: begin
          end
        endcase
      end
    end else if (byte_start) begin
      addr_ff <= nxt_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page latch: columns hold the last byte written to them
  page_buf #(.DEPTH(256), .AW(8)) u_page (
    .clk(REF_CLK),
    .rst_n(rst_n_ff),
    .clr(pb_clr),
    .wr_en(pb_we),
    .wr_addr(col_ff),
    .wr_data(nxt_sh[7:0]),
    .rd_addr(pcol_ff[7:0]),
    .rd_data_ff(pb_data),
    .rd_valid_ff(pb_valid)
  );

  assign start_pgm = cs_rise && st_ff == ST_PDATA && cnt_ff == BYTE_CLKS && got_byte_ff;
  assign wel_drop = pst_ff == P_COPY && pcol_ff == 9'h100;

  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pst_ff <= P_IDLE;
      pcol_ff <= 9'h000;
      ptimer_ff <= 24'h000000;
      page_ff <= 16'h0000;
      wip_ff <= 1'b0;
    end else begin
      unique case (pst_ff)
        P_IDLE: begin
          if (start_pgm) begin
            pst_ff <= P_COPY;
            wip_ff <= 1'b1;
            pcol_ff <= 9'h000;
            page_ff <= addr_ff[23:8];
          end
        end
        P_COPY: begin
          pcol_ff <= pcol_ff + 9'h001;
          if (pcol_ff == 9'h100) begin
            pst_ff <= P_WAIT;
            ptimer_ff <= 24'(PROG_CYCLES);
          end
        end
        P_WAIT: begin
          ptimer_ff <= ptimer_ff - 24'h000001;
          if (ptimer_ff <= 24'h000001) begin
            pst_ff <= P_IDLE;
            wip_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // only written columns reach the array, so the rest of the page is kept
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wr_en_ff <= 1'b0;
      wr_addr_ff <= 24'h000000;
      wr_data_ff <= 8'h00;
    end else begin
      wr_en_ff <= pst_ff == P_COPY && pcol_ff != 9'h000 && pb_valid;
      wr_addr_ff <= {page_ff, pcol_ff[7:0] - 8'h01};
      wr_data_ff <= pb_data;
    end
  end

  // set wins, though busy frames never reach the enable decode
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wel_ff <= 1'b0;
    end else if (cs_rise && st_ff == ST_DONE && cmd_ff == OP_WR_ENABLE) begin
      wel_ff <= 1'b1;
    end else if (wel_drop || (cs_rise && st_ff == ST_DONE && cmd_ff == OP_WR_DISABLE)) begin
      wel_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    stat_byte = 8'h00;
    if (cmd_ff == OP_STAT_HI) begin
      stat_byte[STAT_QE_POS] = QUAD_ENABLE_BIT;
    end else begin
      stat_byte[STAT_WIP_POS] = wip_ff;
      stat_byte[STAT_WEL_POS] = wel_ff;
    end
  end

  assign byte_start = sclk_fall && !cs_s && st_ff == ST_DOUT && slot_ff == 3'h0;

  // drive on falling edges so the host samples stable lines on rising ones
  always_ff @(posedge REF_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      out_ff <= 4'h0;
      oe_ff <= 4'h0;
      obyte_ff <= 8'h00;
      slot_ff <= 3'h0;
    end else if (cs_s) begin
      oe_ff <= 4'h0;
      slot_ff <= 3'h0;
    end else if (sclk_fall && (st_ff == ST_DOUT || st_ff == ST_SOUT)) begin
      oe_ff <= lane_mask(lane_ff);
      if (slot_ff == 3'h0) begin
        out_ff <= emit(st_ff == ST_SOUT ? stat_byte : ARRAY_RD_DATA, lane_ff);
        obyte_ff <= (st_ff == ST_SOUT ? stat_byte : ARRAY_RD_DATA) << (4'h1 << lane_ff);
        slot_ff <= 3'(8 >> lane_ff) - 3'h1;
      end else begin
        out_ff <= emit(obyte_ff, lane_ff);
        obyte_ff <= obyte_ff << (4'h1 << lane_ff);
        slot_ff <= slot_ff - 3'h1;
      end
    end
  end

  assign QUAD_LINE_OUT = out_ff;
  assign QUAD_LINE_OE = oe_ff;
  assign ARRAY_RD_ADDR = addr_ff;
  assign ARRAY_WR_EN = wr_en_ff;
  assign ARRAY_WR_ADDR = wr_addr_ff;
  assign ARRAY_WR_DATA = wr_data_ff;
  assign WRITE_ENABLE_LATCH = wel_ff;
  assign WRITE_IN_PROGRESS = wip_ff;
  assign WRAP_DISABLE_BIT = wrap_dis_ff;
  assign WRAP_LENGTH_BITS = wrap_len_ff;
  assign CONTINUOUS_MODE_ACTIVE = cont_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_ff);

  sequence launch_s;
    cs_rise && st_ff == ST_PDATA && cnt_ff == BYTE_CLKS && got_byte_ff && !wip_ff;
  endsequence
  sequence mode_done_s;
    sclk_rise && !cs_s && st_ff == ST_MODE && cnt_ff == 6'h01;
  endsequence

  wip_launch_a: assert property (launch_s |=> wip_ff && pst_ff == P_COPY)
    else $error("program cycle did not start on whole byte deselect");
  wel_gate_a: assert property (launch_s |-> wel_ff)
    else $error("program started without write enable latch");
  partial_abort_a: assert property (cs_rise && st_ff == ST_PDATA && cnt_ff != BYTE_CLKS && !wip_ff |=> !wip_ff)
    else $error("program started on a partial byte");
  quad_gate_a: assert property (op_last && op == OP_QUAD_IO && !QUAD_ENABLE_BIT |=> st_ff == ST_SKIP)
    else $error("quad read accepted without quad enable");
  cont_enter_a: assert property (mode_done_s and nxt_sh[5:4] == CONT_MATCH |=> cont_ff)
    else $error("continuous mode not entered");
  cont_leave_a: assert property (mode_done_s and nxt_sh[5:4] != CONT_MATCH |=> !cont_ff)
    else $error("continuous mode not left");
  cont_start_a: assert property (cont_ff && st_ff == ST_IDLE && !cs_s |=> st_ff == ST_ADDR)
    else $error("opcode expected in continuous mode");
  wrap_step_a: assert property (byte_start && wrap_on |=> ((addr_ff[7:0] ^ $past(addr_ff[7:0])) & ~$past(wmask)) == 8'h00)
    else $error("wrap burst left its section");
  seq_step_a: assert property (byte_start && !wrap_on |=> addr_ff == $past(addr_ff) + 24'h000001)
    else $error("read address did not advance by one");
  wel_drop_a: assert property ($fell(wip_ff) |-> !wel_ff)
    else $error("write enable latch still set after program");
  busy_skip_a: assert property (op_last && wip_ff && op != OP_STAT_LO && op != OP_STAT_HI |=> st_ff == ST_SKIP)
    else $error("program accepted while busy");
endmodule
`default_nettype wire

/* File: bench/flash_host.sv */
/*
  Host-side model of the serial link: select, mode 0 serial clock, data lines.
  Assumes the bench resolves each line from the device's enable alone, the host driving otherwise.
*/
`default_nettype none
module flash_host
  import flash_seq_pkg::*;
(
  // clock
  input wire logic clk,
  // link
  output logic cs_n,
  output logic sclk,
  output logic [3:0] dq,
  input wire logic [3:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    dq = 4'h0;
  end
  // released lines show the inverse, so a stale value never looks right
  task automatic tick(input logic [3:0] d, input logic drv, output logic [3:0] q);
    dq <= drv ? d : ~dq;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    q = dq_in;
    sclk <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b, input int w, input logic drv, output logic [7:0] r);
    logic [3:0] q;
    for (int i = 0; i < 8 / w; i++) begin
      tick(4'((b >> (8 - w * (i + 1))) & ((1 << w) - 1)), drv, q);
      r = (w == 1) ? {r[6:0], q[1]} : (w == 2) ? {r[5:0], q[1:0]} : {r[3:0], q};
    end
  endtask
  task automatic sel();
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // select rises only after the last whole unit
  task automatic desel();
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // opcode-only frame, optionally one byte read back on line 1
  task automatic cmd(input logic [7:0] op, input logic rd, output logic [7:0] r);
    sel();
    xfer(op, 1, 1, r);
    if (rd) xfer(8'h00, 1, 1'b0, r);
    desel();
  endtask
  task automatic wrap_cfg(input logic [7:0] wb);
    logic [7:0] r;
    sel();
    xfer(OP_SET_WRAP, 1, 1, r);
    repeat (3) xfer(8'h00, 4, 1, r);
    xfer(wb, 4, 1, r);
    desel();
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
/*
  Self-checking bench for the flash command sequencer.
  Assumes the host model above and a behavioural array behind the read port.
*/
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module testbench
  import flash_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, qe = 1'b0, cs_n, sclk, write_enable_latch, write_in_progress, wdis, cont, wr_en, oe_seen;
  logic [4:0] bp = 5'h00;
  logic [3:0] hdq, lin, out, oe;
  logic [1:0] wlen;
  logic [23:0] rd_a, wr_a, a;
  logic [7:0] rd_d, wr_d, r, pd[258], ex[256];
  logic [15:0] seed = 16'h2636;
  logic [31:0] wq[$];
  int miscompares = 0, tests_run = 0, cyc = 0, sz;
  always #20 clk = ~clk;
  assign lin = (oe & out) | (~oe & hdq);
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5a;
  endfunction
  assign rd_d = mem(rd_a);
  function automatic logic [23:0] exp_a(input logic [23:0] x, input int i, input int s);
    logic [23:0] m;
    m = 24'(s - 1);
    return (s == 0) ? x + 24'(i) : (x & ~m) | ((x + 24'(i)) & m);
  endfunction
  flash_host flash_host_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .dq(hdq), .dq_in(lin));
  flash_cmd_seq #(.PROG_CYCLES(400)) flash_cmd_seq_inst (.REF_CLK(clk), .RESET_N(rst_n), .CS_N(cs_n),
    .SCLK(sclk), .QUAD_LINE_IN(lin), .QUAD_LINE_OUT(out), .QUAD_LINE_OE(oe), .QUAD_ENABLE_BIT(qe),
    .BLOCK_PROTECT_BITS(bp), .WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS(write_in_progress), .WRAP_DISABLE_BIT(wdis),
    .WRAP_LENGTH_BITS(wlen), .CONTINUOUS_MODE_ACTIVE(cont), .ARRAY_RD_ADDR(rd_a), .ARRAY_RD_DATA(rd_d),
    .ARRAY_WR_EN(wr_en), .ARRAY_WR_ADDR(wr_a), .ARRAY_WR_DATA(wr_d));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (|oe) oe_seen = 1'b1;
    if (wr_en) wq.push_back({wr_a, wr_d});
    if (cyc == 50000) begin
      miscompares++;
      finish_test();
    end
  end
  function automatic void rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
  endfunction
  // op of zero means a continuation frame that starts with the address
  task automatic rd_frame(input logic [7:0] op, input int w, input logic [23:0] x, input logic [7:0] m,
    input int dum, input int n, input int s);
    logic [3:0] q;
    flash_host_inst.sel();
    if (op != 8'h00) flash_host_inst.xfer(op, 1, 1, r);
    for (int i = 2; i >= 0; i--) flash_host_inst.xfer(x[i*8+:8], w, 1, r);
    flash_host_inst.xfer(m, w, 1, r);
    repeat (dum) flash_host_inst.tick(4'h0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      flash_host_inst.xfer(8'h00, w, 1'b0, r);
      `CHK(r, mem(exp_a(x, i, s)))
    end
    flash_host_inst.desel();
  endtask
  task automatic prog(input logic [23:0] x, input int n, input int extra);
    logic [3:0] q;
    wq.delete();
    flash_host_inst.sel();
    flash_host_inst.xfer(OP_PAGE_PROG, 1, 1, r);
    for (int i = 2; i >= 0; i--) flash_host_inst.xfer(x[i*8+:8], 1, 1, r);
    for (int i = 0; i < n; i++) begin
      rnd();
      pd[i] = seed[7:0];
      flash_host_inst.xfer(pd[i], 1, 1, r);
    end
    repeat (extra) flash_host_inst.tick(4'h1, 1'b1, q);
    flash_host_inst.desel();
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({wdis, cont, write_enable_latch}, 3'b100)
    rnd();
    a = {seed, seed[15:8]};
    rd_frame(OP_DUAL_IO, 2, a, 8'h20, 0, 3, 0);
    `CHK(cont, 1'b1)
    rd_frame(8'h00, 2, a + 24'h5, 8'hff, 0, 2, 0);
    `CHK(cont, 1'b0)
    $display("dual read done");
    oe_seen = 1'b0;
    rd_frame(OP_QUAD_IO, 4, a, 8'h00, 4, 0, 0);
    `CHK(oe_seen, 1'b0)
    qe <= 1'b1;
    for (int l = 0; l < 4; l++) begin
      flash_host_inst.wrap_cfg({1'b0, 2'(l), 5'h00});
      `CHK({wdis, wlen}, {1'b0, 2'(l)})
      rnd();
      sz = 8 << l;
      a = {seed, (seed[7:0] & ~8'(sz - 1)) | 8'(sz - 2)};
      rd_frame(l[0] ? OP_QUAD_WORD : OP_QUAD_IO, 4, a, 8'h20, l[0] ? 2 : 4, 3, sz);
      rd_frame(8'h00, 4, a, 8'h00, l[0] ? 2 : 4, 3, sz);
    end
    flash_host_inst.wrap_cfg(8'h10);
    `CHK(wdis, 1'b1)
    flash_host_inst.cmd(OP_STAT_HI, 1'b1, r);
    `CHK(r[1], 1'b1)
    $display("wrap read done");
    prog(a, 1, 0);
    `CHK(write_in_progress, 1'b0)
    flash_host_inst.cmd(OP_WR_ENABLE, 1'b0, r);
    `CHK(write_enable_latch, 1'b1)
    flash_host_inst.cmd(OP_WR_DISABLE, 1'b0, r);
    `CHK(write_enable_latch, 1'b0)
    flash_host_inst.cmd(OP_WR_ENABLE, 1'b0, r);
    `CHK(write_enable_latch, 1'b1)
    prog(a, 1, 3);
    `CHK(write_in_progress, 1'b0)
    bp <= 5'h07;
    prog(a, 1, 0);
    repeat (300) @(posedge clk);
    `CHK(wq.size(), 0)
    bp <= 5'h00;
    prog({a[23:8], 8'hff}, 258, 0);
    `CHK(write_in_progress, 1'b1)
    flash_host_inst.cmd(OP_STAT_LO, 1'b1, r);
    `CHK(r[0], 1'b1)
    oe_seen = 1'b0;
    rd_frame(OP_DUAL_IO, 2, a, 8'h00, 0, 0, 0);
    `CHK(oe_seen, 1'b0)
    for (int i = 0; i < 1000 && write_in_progress !== 1'b0; i++) @(posedge clk);
    `CHK({write_in_progress, write_enable_latch}, 2'b00)
    for (int i = 0; i < 258; i++) ex[8'(255 + i)] = pd[i];
    `CHK(wq.size(), 256)
    for (int c = 0; c < 256 && c < wq.size(); c++) `CHK(wq[c], {a[23:8], 8'(c), ex[c]})
    $display("page program done");
    finish_test();
  end
endmodule
`default_nettype wire
